// [core/msrc_cfg.svh]
// offsets, field positions, reset values and timing counts of the reset controller
`ifndef MSRC_CFG_SVH
`define MSRC_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define MSRC_OFF_CTRL       12'h000
`define MSRC_OFF_SOURCE     12'h004
`define MSRC_OFF_IRQ_STAT   12'h008
`define MSRC_OFF_IRQ_MASK   12'h00c
`define MSRC_OFF_HRCW       12'h010
`define MSRC_OFF_HRCW_ACT   12'h014
`define MSRC_OFF_STRAPS     12'h018
`define MSRC_OFF_STATE      12'h01c

// ****************************************
// field positions
// ****************************************
`define MSRC_CTRL_WD_EN     0
`define MSRC_CTRL_BM_EN     1
`define MSRC_SRC_POR        0
`define MSRC_SRC_EXT_HARD   1
`define MSRC_SRC_WATCHDOG   2
`define MSRC_SRC_BUS_MON    3
`define MSRC_SRC_EXT_SOFT   4
`define MSRC_SRC_TAP        5

// ****************************************
// reset values
// ****************************************
`define MSRC_CTRL_RST       2'h3
`define MSRC_MASK_RST       6'h00
`define MSRC_HRCW_RST       32'h0000_0000

// ****************************************
// timing counts, in clock cycles
// ****************************************
`define MSRC_POR_HOLD_CYC   11'h400
`define MSRC_HARD_REL_CYC   11'h200
`define MSRC_SOFT_REL_CYC   11'h203
`define MSRC_GUARD_CYC      11'h004

`endif

// [core/msrc_pkg.sv]
// types shared by the reset controller files
package msrc_pkg;
  typedef enum logic [2:0] {
    ST_POR_IN,
    ST_POR_HOLD,
    ST_PLL_WAIT,
    ST_RELEASE,
    ST_GUARD,
    ST_IDLE
  } msrc_state_t;

  typedef enum logic [1:0] {
    FL_NONE,
    FL_POR,
    FL_HARD,
    FL_SOFT
  } msrc_flow_t;

  typedef logic [5:0] msrc_cause_t;
endpackage : msrc_pkg

// [core/msrc_sync.sv]
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module msrc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] stable_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // reset value stands until real pin levels fill all three stages, so an idle-high line
  // shows no false low after reset; a flop under async reset sees only a constant
  logic [1:0] init_cnt_reg;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_cnt_reg <= 2'h0;
    end else if (init_cnt_reg != 2'h3) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic val_reg;
      always_ff @(posedge sys_clk_in) begin
        if (init_cnt_reg != 2'h3) begin
          val_reg <= rst_val_in[i];
        end else if (s2_reg[i] == s3_reg[i]) begin
          val_reg <= s3_reg[i];
        end
      end
      assign stable_out[i] = val_reg;
    end
  endgenerate
endmodule : msrc_sync

// [core/msrc_core.sv]
// multi-source reset controller with apb register access
// Summary of operation
// - power-on input starts power-on flow, resetting cores and the pll; apb-written registers keep their values
// - power-on flow drives both lines, holds cores, samples configuration
// - straps captured only by power-on reset, untouched by other flows
// - soft line stays driven whenever hard line is driven
// - both lines open-drain: device only pulls low or releases
// - hard flow drives both lines, resets cores, samples configuration
// - hard reset reloads configuration from the 32-bit configuration word
// - external soft line low counts only while device asserts no reset
// - soft flow drives soft line, resets cores, keeps configuration
// - enabled watchdog expiry starts internal hard flow
// - enabled bus monitor expiry starts internal hard flow
// - tap host reset command starts internal soft flow
// - readable record shows sources of the most recent reset
// - internal power-on reset held 1024 cycles after input release
// - hard line released 512 cycles after pll lock
// - soft line released 515 cycles after pll lock
// - straps latched when power-on input is released
`timescale 1ns/1ps
`include "msrc_cfg.svh"
module msrc_core (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        power_on_reset_n_in,
  input  wire logic        hard_reset_line_in,
  output logic             hard_reset_line_out,
  output logic             hard_reset_line_oe_out,
  input  wire logic        soft_reset_line_in,
  output logic             soft_reset_line_out,
  output logic             soft_reset_line_oe_out,
  input  wire logic        system_pll_lock_in,
  output logic             system_pll_reset_out,
  output logic             por_internal_out,
  output logic             core_reset_out,
  output logic             config_sample_out,
  input  wire logic        watchdog_expired_in,
  input  wire logic        bus_monitor_expired_in,
  input  wire logic        tap_host_reset_in,
  input  wire logic [1:0]  clock_mode_straps_in,
  input  wire logic        reset_conf_mode_in,
  input  wire logic [2:0]  boot_mode_in,
  input  wire logic [3:0]  chip_identifier_straps_in,
  input  wire logic        port64_sel_in,
  output logic [10:0]      straps_out,
  output logic [31:0]      hard_config_word_out,
  output logic             irq_out
);
  import msrc_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [14:0] pins_raw;
  logic [14:0] pins_sync;
  logic [14:0] pins_rst;
  logic        por_low;
  logic        hard_low;
  logic        soft_low;
  logic        pll_lock;
  logic [10:0] straps_now;

  assign pins_raw = {clock_mode_straps_in, reset_conf_mode_in, boot_mode_in,
                     chip_identifier_straps_in, port64_sel_in, system_pll_lock_in,
                     soft_reset_line_in, hard_reset_line_in, power_on_reset_n_in};
  // lines settle idle-high, power-on input taken as asserted until seen
  assign pins_rst = 15'h0006;

  msrc_sync #(.W(15)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   (pins_raw),
    .rst_val_in (pins_rst),
    .stable_out (pins_sync)
  );

  assign por_low    = !pins_sync[0];
  assign hard_low   = !pins_sync[1];
  assign soft_low   = !pins_sync[2];
  assign pll_lock   = pins_sync[3];
  assign straps_now = pins_sync[14:4];

  // ****************************************
  // registers and sequencer state
  // ****************************************
  msrc_state_t state_reg;
  msrc_flow_t  flow_reg;
  logic [10:0] cnt_reg;
  logic [1:0]  ctrl_reg;
  msrc_cause_t source_reg;
  msrc_cause_t irq_stat_reg;
  msrc_cause_t irq_mask_reg;
  logic [31:0] hrcw_reg;
  logic [31:0] hrcw_act_reg;
  logic [10:0] straps_reg;
  logic        cfg_load_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  // ****************************************
  // request arbitration
  // ****************************************
  logic        wd_req;
  logic        bm_req;
  logic        ext_hard_req;
  logic        ext_soft_req;
  logic        hard_req;
  logic        soft_req;
  logic        start_hard;
  logic        start_soft;
  logic        strap_cap;
  logic        hard_drive;
  logic        soft_drive;
  msrc_cause_t cause;

  assign wd_req = watchdog_expired_in && ctrl_reg[`MSRC_CTRL_WD_EN];
  assign bm_req = bus_monitor_expired_in && ctrl_reg[`MSRC_CTRL_BM_EN];
  // our own drive echoes back for a few cycles, so guard ignores the lines
  assign ext_hard_req = hard_low && !hard_drive && state_reg != ST_GUARD;
  assign ext_soft_req = soft_low && state_reg == ST_IDLE;
  assign hard_req = wd_req || bm_req || ext_hard_req;
  assign soft_req = ext_soft_req || tap_host_reset_in;
  // power-on beats hard beats soft; a running flow is only escalated
  assign start_hard = !por_low && hard_req && flow_reg != FL_POR &&
                      flow_reg != FL_HARD;
  assign start_soft = !por_low && !start_hard && soft_req && flow_reg == FL_NONE;
  assign strap_cap  = state_reg == ST_POR_IN && !por_low;

  always_comb begin
    cause = '0;
    cause[`MSRC_SRC_EXT_HARD] = start_hard && ext_hard_req;
    cause[`MSRC_SRC_WATCHDOG] = start_hard && wd_req;
    cause[`MSRC_SRC_BUS_MON]  = start_hard && bm_req;
    cause[`MSRC_SRC_EXT_SOFT] = start_soft && ext_soft_req;
    cause[`MSRC_SRC_TAP]      = start_soft && tap_host_reset_in;
    cause[`MSRC_SRC_POR]      = por_low && state_reg != ST_POR_IN;
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_POR_IN;
      flow_reg  <= FL_POR;
      cnt_reg   <= 11'h000;
    end else if (por_low) begin
      state_reg <= ST_POR_IN;
      flow_reg  <= FL_POR;
      cnt_reg   <= 11'h000;
    end else if (start_hard) begin
      state_reg <= ST_RELEASE;
      flow_reg  <= FL_HARD;
      cnt_reg   <= 11'h000;
    end else if (start_soft) begin
      state_reg <= ST_RELEASE;
      flow_reg  <= FL_SOFT;
      cnt_reg   <= 11'h000;
    end else begin
      case (state_reg)
        ST_POR_IN: begin
          state_reg <= ST_POR_HOLD;
          cnt_reg   <= 11'h000;
        end
        ST_POR_HOLD: begin
          cnt_reg <= cnt_reg + 11'h001;
          if (cnt_reg == `MSRC_POR_HOLD_CYC - 11'h001) begin
            state_reg <= ST_PLL_WAIT;
          end
        end
        ST_PLL_WAIT: begin
          cnt_reg <= 11'h000;
          if (pll_lock) begin
            state_reg <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          cnt_reg <= cnt_reg + 11'h001;
          if (cnt_reg == `MSRC_SOFT_REL_CYC - 11'h001) begin
            state_reg <= ST_GUARD;
            flow_reg  <= FL_NONE;
            cnt_reg   <= 11'h000;
          end
        end
        ST_GUARD: begin
          cnt_reg <= cnt_reg + 11'h001;
          if (cnt_reg == `MSRC_GUARD_CYC - 11'h001) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cnt_reg   <= 11'h000;
        end
      endcase
    end
  end

  // ****************************************
  // line drive and reset outputs
  // ****************************************
  assign hard_drive = (flow_reg == FL_POR || flow_reg == FL_HARD) &&
                      (state_reg != ST_RELEASE ||
                       cnt_reg < `MSRC_HARD_REL_CYC);
  assign soft_drive = flow_reg != FL_NONE || hard_drive;

  // open drain: the data output is always low, only the enable moves
  assign hard_reset_line_out    = 1'b0;
  assign hard_reset_line_oe_out = hard_drive;
  assign soft_reset_line_out    = 1'b0;
  assign soft_reset_line_oe_out = soft_drive;
  assign por_internal_out       = state_reg == ST_POR_IN || state_reg == ST_POR_HOLD;
  assign system_pll_reset_out   = por_internal_out;
  assign core_reset_out         = soft_drive;
  assign config_sample_out      = cfg_load_reg;
  assign straps_out             = straps_reg;
  assign hard_config_word_out   = hrcw_act_reg;

  // ****************************************
  // configuration capture
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      straps_reg <= 11'h000;
    end else if (strap_cap) begin
      straps_reg <= straps_now;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrcw_act_reg <= `MSRC_HRCW_RST;
      cfg_load_reg <= 1'b0;
    end else begin
      cfg_load_reg <= strap_cap || start_hard;
      if (strap_cap || start_hard) begin
        hrcw_act_reg <= hrcw_reg;
      end
    end
  end

  // ****************************************
  // source record and interrupt
  // ****************************************
  logic apb_setup;
  logic apb_access;
  logic rd_irq;

  assign apb_setup  = psel_in && !penable_in;
  assign apb_access = psel_in && penable_in;
  assign rd_irq     = apb_access && !pwrite_in && paddr_in == `MSRC_OFF_IRQ_STAT;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      source_reg <= 6'h01;
    end else if (|cause) begin
      source_reg <= cause;
    end
  end

  // set wins; a read clears only the bits its setup snapshot reported, so none is lost
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_reg <= 6'h00;
    end else begin
      irq_stat_reg <= (rd_irq ? irq_stat_reg & ~prdata_reg[5:0] : irq_stat_reg) | cause;
    end
  end

  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  logic wr_en;
  assign wr_en = apb_access && pwrite_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg     <= `MSRC_CTRL_RST;
      irq_mask_reg <= `MSRC_MASK_RST;
      hrcw_reg     <= `MSRC_HRCW_RST;
    end else if (wr_en) begin
      case (paddr_in)
        `MSRC_OFF_CTRL:     ctrl_reg     <= pwdata_in[1:0];
        `MSRC_OFF_IRQ_MASK: irq_mask_reg <= pwdata_in[5:0];
        `MSRC_OFF_HRCW:     hrcw_reg     <= pwdata_in;
        default: begin
        end
      endcase
    end
  end

  // read data is prepared in the setup cycle so it comes from a flop in access
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      case (paddr_in)
        `MSRC_OFF_CTRL:     prdata_reg <= {30'h0, ctrl_reg};
        `MSRC_OFF_SOURCE:   prdata_reg <= {26'h0, source_reg};
        `MSRC_OFF_IRQ_STAT: prdata_reg <= {26'h0, irq_stat_reg};
        `MSRC_OFF_IRQ_MASK: prdata_reg <= {26'h0, irq_mask_reg};
        `MSRC_OFF_HRCW:     prdata_reg <= hrcw_reg;
        `MSRC_OFF_HRCW_ACT: prdata_reg <= hrcw_act_reg;
        `MSRC_OFF_STRAPS:   prdata_reg <= {21'h0, straps_reg};
        `MSRC_OFF_STATE:    prdata_reg <= {24'h0, 1'b0, state_reg, flow_reg,
                                           soft_drive, hard_drive};
        default:            pslverr_reg <= 1'b1;
      endcase
    end
  end

  assign pready_out  = 1'b1;
  assign prdata_out  = prdata_reg;
  assign pslverr_out = pslverr_reg && apb_access;

  // ****************************************
  // assertions
  // ****************************************
  property p_por_flow;
    @(posedge sys_clk_in) disable iff (rst_in)
    por_low |=> flow_reg == FL_POR && system_pll_reset_out;
  endproperty
  a_por_flow: assert property (p_por_flow) else $error("por flow not taken");

  property p_por_drive;
    @(posedge sys_clk_in) disable iff (rst_in)
    flow_reg == FL_POR && state_reg != ST_RELEASE |-> hard_reset_line_oe_out && core_reset_out;
  endproperty
  a_por_drive: assert property (p_por_drive) else $error("por flow not driving");

  property p_straps_keep;
    @(posedge sys_clk_in) disable iff (rst_in)
    !strap_cap |=> $stable(straps_reg);
  endproperty
  a_straps_keep: assert property (p_straps_keep) else $error("straps changed");

  property p_soft_with_hard;
    @(posedge sys_clk_in) disable iff (rst_in)
    hard_reset_line_oe_out |-> soft_reset_line_oe_out;
  endproperty
  a_soft_with_hard: assert property (p_soft_with_hard) else $error("soft not held");

  property p_open_drain;
    @(posedge sys_clk_in) disable iff (rst_in)
    !hard_reset_line_out && !soft_reset_line_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_hrcw_load;
    @(posedge sys_clk_in) disable iff (rst_in)
    start_hard |=> hrcw_act_reg == $past(hrcw_reg) && config_sample_out;
  endproperty
  a_hrcw_load: assert property (p_hrcw_load) else $error("config word not loaded");

  property p_soft_keep;
    @(posedge sys_clk_in) disable iff (rst_in)
    flow_reg == FL_SOFT && !por_low && !start_hard |=> $stable(hrcw_act_reg);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft flow changed config");

  property p_wd_hard;
    @(posedge sys_clk_in) disable iff (rst_in)
    wd_req && !por_low && flow_reg != FL_POR && flow_reg != FL_HARD |=> flow_reg == FL_HARD;
  endproperty
  a_wd_hard: assert property (p_wd_hard) else $error("watchdog ignored");

  property p_bm_hard;
    @(posedge sys_clk_in) disable iff (rst_in)
    bm_req && !por_low && flow_reg != FL_POR && flow_reg != FL_HARD |=> flow_reg == FL_HARD;
  endproperty
  a_bm_hard: assert property (p_bm_hard) else $error("bus monitor ignored");

  property p_hard_rel;
    @(posedge sys_clk_in) disable iff (rst_in)
    $fell(hard_drive) && !por_low |-> $past(cnt_reg) == `MSRC_HARD_REL_CYC - 11'h001
      ##3 $fell(soft_drive);
  endproperty
  a_hard_rel: assert property (p_hard_rel) else $error("hard release timing");
endmodule : msrc_core

// [test/msrc_board.sv]
// board side of the two open-drain reset lines, with pull-ups and other devices
`timescale 1ns/1ps
module msrc_board (
  input  wire logic hard_oe_in,
  input  wire logic hard_drv_in,
  input  wire logic soft_oe_in,
  input  wire logic soft_drv_in,
  input  wire logic hard_pull_in,
  input  wire logic soft_pull_in,
  output logic      hard_line_out,
  output logic      soft_line_out
);
  // ****************************************
  // wired-and lines
  // ****************************************
  // a released line floats up to the pull-up level, never holds the last value
  assign hard_line_out = (hard_oe_in ? hard_drv_in : 1'b1) & ~hard_pull_in;
  assign soft_line_out = (soft_oe_in ? soft_drv_in : 1'b1) & ~soft_pull_in;
endmodule : msrc_board

// [test/tb_msrc_core.sv]
// self-checking bench for the reset controller
`timescale 1ns/1ps
`include "msrc_cfg.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_msrc_core;
  logic        sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hcw, pd;
  logic        por_n, pll_lock, wd, bm, tap, hard_pull, soft_pull, p64, rc;
  logic        hard_line, soft_line, hard_oe, soft_oe, hard_drv, soft_drv;
  logic        pll_rst, por_int, core_rst, irq, perr, cfgs;
  logic [1:0]  cm;
  logic [2:0]  boot;
  logic [3:0]  chip;
  logic [10:0] straps;
  int          error_cnt, n_tests, hc, sc, cc;

  msrc_core msrc_core_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .power_on_reset_n_in(por_n), .hard_reset_line_in(hard_line),
    .hard_reset_line_out(hard_drv), .hard_reset_line_oe_out(hard_oe),
    .soft_reset_line_in(soft_line), .soft_reset_line_out(soft_drv),
    .soft_reset_line_oe_out(soft_oe), .system_pll_lock_in(pll_lock),
    .system_pll_reset_out(pll_rst), .por_internal_out(por_int), .core_reset_out(core_rst),
    .config_sample_out(cfgs), .watchdog_expired_in(wd), .bus_monitor_expired_in(bm),
    .tap_host_reset_in(tap), .clock_mode_straps_in(cm), .reset_conf_mode_in(rc),
    .boot_mode_in(boot), .chip_identifier_straps_in(chip), .port64_sel_in(p64),
    .straps_out(straps), .hard_config_word_out(hcw), .irq_out(irq));
  msrc_board msrc_board_i (.hard_oe_in(hard_oe), .hard_drv_in(hard_drv), .soft_oe_in(soft_oe),
    .soft_drv_in(soft_drv), .hard_pull_in(hard_pull), .soft_pull_in(soft_pull),
    .hard_line_out(hard_line), .soft_line_out(soft_line));

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************
  // access and flow tasks
  // ****************************************
  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v,
                     output logic [31:0] rd, output logic err);
    int i;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= v;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin error_cnt++; stop_test(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // one idle edge so the next request never reassigns psel in this step
    @(posedge sys_clk_in);
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    `CHK(nm, exp, d)
  endtask : rd_chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, v, d, e);
  endtask : wr

  // counts sampled edges with each line driven until the soft line lets go
  task automatic flow(input logic hp, input logic sp, input int at);
    int i;
    hc = 0; sc = 0; cc = 0;
    for (i = 0; i < 3000 && !(sc > 0 && soft_oe === 1'b0); i++) begin
      @(posedge sys_clk_in);
      if (hard_oe === 1'b1) hc++;
      if (cfgs === 1'b1) cc++;
      if (soft_oe === 1'b1) sc++;
      if (i == at) begin hard_pull <= hp; soft_pull <= sp; end
      if (i == at + 8) begin hard_pull <= 1'b0; soft_pull <= 1'b0; end
    end
    if (i == 3000) begin error_cnt++; stop_test(); end
    repeat (8) @(posedge sys_clk_in);
  endtask : flow

  // 0 watchdog, 1 bus monitor, otherwise tap host reset
  task automatic pulse(input int k);
    if (k == 0) wd <= 1'b1;
    else if (k == 1) bm <= 1'b1;
    else tap <= 1'b1;
    @(posedge sys_clk_in);
    {wd, bm, tap} <= 3'b000;
  endtask : pulse

  task automatic por_seq;
    int i;
    pll_lock <= 1'b0; por_n <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    `CHK("por_int", 1'b1, por_int & pll_rst)
    `CHK("cores_lines", 3'b111, {core_rst, hard_oe, soft_oe})
    por_n <= 1'b1;
    for (i = 0; i < 1100 && por_int !== 1'b0; i++) @(posedge sys_clk_in);
    `CHK("por_hold", 1'b1, i >= 1024 && i <= 1030)
    pll_lock <= 1'b1;
    flow(1'b0, 1'b0, 0);
    // lock crosses the pin synchroniser before the 512 count starts
    `CHK("hard_rel", 1'b1, hc >= 516 && hc <= 520)
    `CHK("soft_rel", 3, sc - hc)
  endtask : por_seq

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; por_n = 1'b0; pll_lock = 1'b0; wd = 1'b0; bm = 1'b0; tap = 1'b0;
    hard_pull = 1'b0; soft_pull = 1'b0; error_cnt = 0; n_tests = 0;
    {cm, rc, boot, chip, p64} = {2'h2, 1'b1, 3'h5, 4'ha, 1'b1};
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    por_seq();
    `CHK("straps", 11'h5b5, straps)
    `CHK("hcw_rst", 32'h0, hcw)
    rd_chk(`MSRC_OFF_SOURCE, 32'h01, "src_por");
    rd_chk(`MSRC_OFF_IRQ_STAT, 32'h00, "stat_por");
    rd_chk(`MSRC_OFF_CTRL, 32'h03, "ctrl_rst");
    apb(1'b0, 12'h020, 32'h0, pd, perr);
    `CHK("unmapped_err", 1'b1, perr)
    wr(`MSRC_OFF_HRCW, 32'h1234_abcd);
    wr(`MSRC_OFF_IRQ_MASK, 32'h04);
    {cm, rc, boot, chip, p64} <= {2'h1, 1'b0, 3'h2, 4'h3, 1'b0};
    // watchdog hard flow; an outside soft pull inside it must not count
    pulse(0);
    flow(1'b0, 1'b1, 40);
    `CHK("wd_hard", 512, hc)
    `CHK("wd_soft", 515, sc)
    `CHK("hcw_load", 32'h1234_abcd, hcw)
    `CHK("straps_kept", 11'h5b5, straps)
    `CHK("irq_on", 1'b1, irq)
    rd_chk(`MSRC_OFF_SOURCE, 32'h04, "src_wd");
    rd_chk(`MSRC_OFF_IRQ_STAT, 32'h04, "stat_wd");
    `CHK("irq_off", 1'b0, irq)
    // bus monitor refused while disabled, then accepted
    wr(`MSRC_OFF_CTRL, 32'h01);
    pulse(1);
    repeat (10) @(posedge sys_clk_in);
    `CHK("bm_off", 1'b0, soft_oe)
    wr(`MSRC_OFF_CTRL, 32'h03);
    pulse(1);
    flow(1'b0, 1'b0, 0);
    `CHK("bm_hard", 512, hc)
    `CHK("irq_masked", 1'b0, irq)
    rd_chk(`MSRC_OFF_SOURCE, 32'h08, "src_bm");
    // tap soft flow keeps the configuration
    wr(`MSRC_OFF_HRCW, 32'h5555_0000);
    pulse(2);
    flow(1'b0, 1'b0, 0);
    `CHK("tap_lines", 1'b1, hc == 0 && sc == 515)
    `CHK("hcw_kept", 32'h1234_abcd, hcw)
    rd_chk(`MSRC_OFF_SOURCE, 32'h20, "src_tap");
    // outside parties pull the lines
    flow(1'b1, 1'b0, 0);
    `CHK("ext_hard", 512, hc)
    `CHK("hcw_ext", 32'h5555_0000, hcw)
    `CHK("cfg_pulse", 1, cc)
    rd_chk(`MSRC_OFF_SOURCE, 32'h02, "src_ext_hard");
    flow(1'b0, 1'b1, 0);
    `CHK("ext_soft", 1'b1, hc == 0 && sc == 515)
    rd_chk(`MSRC_OFF_SOURCE, 32'h10, "src_ext_soft");
    flow(1'b1, 1'b1, 0);
    `CHK("both_pull", 512, hc)
    // second power-on takes the new straps
    por_seq();
    `CHK("straps_new", 11'h246, straps)
    rd_chk(`MSRC_OFF_SOURCE, 32'h01, "src_por2");
    stop_test();
  end

  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_msrc_core
